// File: pff_host.v
// Host-side controller driving a 1K x 9 programmable-flag FIFO over its pins
// Assumes FIFO pin inputs synchronous to CLK; AXI4-Lite master elsewhere
//
// How it works
// - Single device: chain input tied low
// - Chain input fed by previous chain output; here driven high from the CTRL expansion bit
// - Load select low first device, else high
// - Load select low in single mode retransmits
// - Load select picks register load source
// - Load order upper threshold then lower
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "pff_defines.vh"

module pff_host #(
  parameter PULSE_CYC = `PFF_PULSE_CYC,
  parameter RECOV_CYC = `PFF_RECOV_CYC
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg         RESET_N,
  output reg         WRITE_N,
  output reg         READ_N,
  output reg         LOAD_SELECT_PIN,
  output reg         CHAIN_INPUT_N,
  output reg  [8:0]  INPUT_BUS,
  input  wire [8:0]  OUTPUT_BUS_I,
  output reg  [8:0]  OUTPUT_BUS_O,
  output reg         OUTPUT_BUS_OE,
  input  wire        LOWER_STATUS_PIN,
  input  wire        UPPER_STATUS_PIN,
  input  wire        SHARED_THIRD_OUTPUT
);

  localparam ST_IDLE = 3'd0;
  localparam ST_LOW  = 3'd1;
  localparam ST_REC  = 3'd2;
  localparam ST_L2   = 3'd3;
  localparam ST_L3   = 3'd4;
  localparam ST_L4   = 3'd5;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  reg [2:0]  cmd_r;
  reg        dir_r;
  reg        exp_r;
  reg        lsel_r;
  reg [8:0]  wdata_r;
  reg [8:0]  rdata_r;
  reg        rval_r;
  reg [17:0] thr_r;
  reg [2:0]  st_r;
  reg [7:0]  cnt_r;
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wd_r;
  reg [2:0]  pend_r;
  reg        ld_second_r;

  wire busy = (st_r != ST_IDLE) || (pend_r != 3'h0);
  wire do_wr = aw_hold_r && w_hold_r && !S_AXI_BVALID;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write side: address and data taken in either order
  always @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wd_r          <= 32'h00000000;
      dir_r         <= 1'b1;
      exp_r         <= 1'b0;
      lsel_r        <= 1'b1;
      wdata_r       <= 9'h000;
      thr_r         <= `PFF_THR_RST;
      pend_r        <= 3'h0;
    end else begin
      S_AXI_AWREADY <= !aw_hold_r && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_hold_r && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        wd_r     <= S_AXI_WDATA;
      end
      if (pend_r != 3'h0)
        pend_r <= 3'h0;
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= 2'b00;
        if (awaddr_r == `PFF_CTRL_OFS) begin
          if (busy)
            S_AXI_BRESP <= 2'b10;
          else begin
            pend_r <= wd_r[2:0];
            dir_r  <= wd_r[`PFF_CTRL_DIR_BIT];
            exp_r  <= wd_r[`PFF_CTRL_EXP_BIT];
            lsel_r <= wd_r[`PFF_CTRL_LSEL_BIT];
          end
        end else if (awaddr_r == `PFF_WDATA_OFS)
          wdata_r <= wd_r[8:0];
        else if (awaddr_r == `PFF_THR_OFS)
          thr_r <= wd_r[17:0];
        else if (awaddr_r != `PFF_STAT_OFS && awaddr_r != `PFF_RDATA_OFS)
          S_AXI_BRESP <= 2'b10;
      end else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read side
  always @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'b00;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        S_AXI_RDATA  <= 32'h00000000;
        if (S_AXI_ARADDR == `PFF_CTRL_OFS)
          S_AXI_RDATA <= {21'h0, lsel_r, exp_r, dir_r, 5'h0, cmd_r};
        else if (S_AXI_ARADDR == `PFF_WDATA_OFS)
          S_AXI_RDATA <= {23'h0, wdata_r};
        else if (S_AXI_ARADDR == `PFF_RDATA_OFS)
          S_AXI_RDATA <= {23'h0, rdata_r};
        else if (S_AXI_ARADDR == `PFF_STAT_OFS)
          S_AXI_RDATA <= {27'h0, rval_r, SHARED_THIRD_OUTPUT,
                          UPPER_STATUS_PIN, LOWER_STATUS_PIN, busy};
        else if (S_AXI_ARADDR == `PFF_THR_OFS)
          S_AXI_RDATA <= {14'h0, thr_r};
        else
          S_AXI_RRESP <= 2'b10;
      end else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer
  always @(posedge CLK) begin
    if (!RST_N) begin
      st_r            <= ST_IDLE;
      cnt_r           <= 8'h00;
      cmd_r           <= 3'h0;
      RESET_N         <= 1'b1;
      WRITE_N         <= 1'b1;
      READ_N          <= 1'b1;
      LOAD_SELECT_PIN <= 1'b1;
      CHAIN_INPUT_N   <= 1'b0;
      INPUT_BUS       <= 9'h000;
      OUTPUT_BUS_O    <= 9'h000;
      OUTPUT_BUS_OE   <= 1'b0;
      rdata_r         <= 9'h000;
      rval_r          <= 1'b0;
      ld_second_r     <= 1'b0;
    end else begin
      CHAIN_INPUT_N <= exp_r;
      if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
      case (st_r)
        ST_IDLE: begin
          LOAD_SELECT_PIN <= exp_r ? lsel_r : 1'b1;
          OUTPUT_BUS_OE   <= 1'b0;
          if (pend_r != 3'h0) begin
            cmd_r <= pend_r;
            cnt_r <= PULSE_CYC[7:0];
            st_r  <= ST_LOW;
            if (pend_r == `PFF_CMD_WRITE) begin
              INPUT_BUS <= wdata_r;
              WRITE_N   <= 1'b0;
            end else if (pend_r == `PFF_CMD_READ) begin
              READ_N <= 1'b0;
              rval_r <= 1'b0;
            end else if (pend_r == `PFF_CMD_RESET) begin
              RESET_N <= 1'b0;
            end else if (pend_r == `PFF_CMD_RETX && !exp_r) begin
              LOAD_SELECT_PIN <= 1'b0;
            end else if (pend_r == `PFF_CMD_LOAD) begin
              RESET_N         <= 1'b0;
              LOAD_SELECT_PIN <= dir_r;
              ld_second_r     <= 1'b0;
              st_r            <= ST_L2;
            end else
              st_r <= ST_IDLE;
          end
        end
        ST_LOW: begin
          if (cnt_r == 8'h00) begin
            if (!READ_N) begin
              rdata_r <= OUTPUT_BUS_I;
              rval_r  <= 1'b1;
            end
            READ_N          <= 1'b1;
            WRITE_N         <= 1'b1;
            RESET_N         <= 1'b1;
            LOAD_SELECT_PIN <= exp_r ? lsel_r : 1'b1;
            cnt_r           <= RECOV_CYC[7:0];
            st_r            <= ST_REC;
          end
        end
        ST_REC: begin
          if (cnt_r == 8'h00)
            st_r <= ST_IDLE;
        end
        ST_L2: begin
          READ_N <= 1'b0;
          if (dir_r)
            INPUT_BUS <= thr_r[8:0];
          else begin
            OUTPUT_BUS_O  <= thr_r[8:0];
            OUTPUT_BUS_OE <= 1'b1;
          end
          cnt_r <= PULSE_CYC[7:0] + 8'h01;
          st_r  <= ST_L3;
        end
        ST_L3: begin
          WRITE_N <= 1'b0;
          if (cnt_r == 8'h00) begin
            WRITE_N <= 1'b1;
            cnt_r   <= RECOV_CYC[7:0];
            st_r    <= ST_L4;
          end
        end
        ST_L4: begin
          if (cnt_r == 8'h00) begin
            if (!ld_second_r) begin
              ld_second_r   <= 1'b1;
              INPUT_BUS     <= thr_r[17:9];
              OUTPUT_BUS_O  <= thr_r[17:9];
              cnt_r         <= PULSE_CYC[7:0] + 8'h01;
              st_r          <= ST_L3;
            end else begin
              READ_N          <= 1'b1;
              RESET_N         <= 1'b1;
              OUTPUT_BUS_OE   <= 1'b0;
              LOAD_SELECT_PIN <= exp_r ? lsel_r : 1'b1;
              cnt_r           <= RECOV_CYC[7:0];
              st_r            <= ST_REC;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: pff_defines.vh
// Constants for the host-side controller of a 1K x 9 programmable-flag FIFO
// Included by the controller; definitions only
`ifndef PFF_DEFINES_VH
`define PFF_DEFINES_VH
// Register offsets (byte addresses)
`define PFF_CTRL_OFS      8'h00
`define PFF_WDATA_OFS     8'h04
`define PFF_RDATA_OFS     8'h08
`define PFF_STAT_OFS      8'h0c
`define PFF_THR_OFS       8'h10
// Command codes in CTRL[2:0]
`define PFF_CMD_WRITE     3'h1
`define PFF_CMD_READ      3'h2
`define PFF_CMD_RESET     3'h3
`define PFF_CMD_LOAD      3'h4
`define PFF_CMD_RETX      3'h5
// Field positions
`define PFF_CTRL_DIR_BIT  8
`define PFF_CTRL_EXP_BIT  9
`define PFF_CTRL_LSEL_BIT 10
`define PFF_STAT_BUSY_BIT 0
`define PFF_STAT_LOW_BIT  1
`define PFF_STAT_UP_BIT   2
`define PFF_STAT_THD_BIT  3
`define PFF_STAT_RVAL_BIT 4
// Timing, ns, and derived cycle counts at the 50 ns clock
`define PFF_CLK_NS        50
`define PFF_PULSE_NS      35
`define PFF_RECOV_NS      10
`define PFF_PULSE_CYC     ((`PFF_PULSE_NS+`PFF_CLK_NS-1)/`PFF_CLK_NS)
`define PFF_RECOV_CYC     ((`PFF_RECOV_NS+`PFF_CLK_NS-1)/`PFF_CLK_NS)
// Reset values
`define PFF_THR_RST       18'h00000
`endif

// File: pff_host_asserts.sv
// Checker for the FIFO-side pins of the host controller
// Bound to pff_host; sees only its top-level ports
`timescale 1ns/10ps
module pff_host_chk #(
  parameter PULSE_CYC = 1
) (
  input wire CLK,
  input wire RST_N,
  input wire RESET_N,
  input wire WRITE_N,
  input wire READ_N,
  input wire LOAD_SELECT_PIN,
  input wire CHAIN_INPUT_N,
  input wire OUTPUT_BUS_OE
);
  reg [3:0] low_cnt_r;
  // Sampled low cycles of the write strobe
  always @(posedge CLK) begin
    low_cnt_r <= WRITE_N ? 4'h0 : low_cnt_r + 4'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  rst_idle_a: assert property ($fell(RESET_N) |-> WRITE_N && READ_N)
    else $error("reset started with a strobe low");
  wr_width_a: assert property ($rose(WRITE_N) |-> low_cnt_r == PULSE_CYC + 1)
    else $error("write strobe width wrong");
  load_rd_a: assert property (!WRITE_N && !RESET_N |-> !READ_N)
    else $error("load write without read low");
  load_hold_a: assert property (!RESET_N && !READ_N |=> !READ_N || RESET_N)
    else $error("read released inside load");
  load_src_a: assert property (OUTPUT_BUS_OE |->
    !RESET_N && !READ_N && !LOAD_SELECT_PIN)
    else $error("output bus driven outside load");
  retx_idle_a: assert property (!LOAD_SELECT_PIN && RESET_N && !CHAIN_INPUT_N
    |-> WRITE_N && READ_N)
    else $error("strobe during retransmit");
endmodule

// File: pff_fifo_model.sv
// Behavioural 1K x 9 programmable-flag FIFO device
// Driven by strobes only; bench resolves the two-way output bus
`timescale 1ns/10ps
module pff_fifo_model (
  input  wire       rs_n,
  input  wire       w_n,
  input  wire       r_n,
  input  wire       lsel,
  input  wire       xi_n,
  input  wire [8:0] d,
  input  wire [8:0] q_in,
  output wire [8:0] q_drv,
  output wire       q_en,
  output wire       ef_n,
  output wire       ff_n,
  output wire       xo_n
);
  reg [8:0]  mem [0:1023];
  reg [10:0] wp = 0;
  reg [10:0] rp = 0;
  reg [8:0]  af = 0;
  reg [8:0]  ae = 0;
  reg        cfg = 0;
  reg        nld = 0;
  wire [10:0] cnt = wp - rp;
  wire        emp = cnt == 11'd0;
  wire        ful = cnt == 11'd1024;
  always @(negedge rs_n) begin
    nld = 0;
    if (!ae[8]) begin
      wp = 0;
      rp = 0;
      cfg = 0;
    end
  end
  always @(posedge w_n) begin
    if (!rs_n && !r_n) begin
      if (nld) ae = lsel ? d : q_in;
      else af = lsel ? d : q_in;
      nld = !nld;
      cfg = 1;
    end else if (rs_n && !ful) begin
      mem[wp[9:0]] = d;
      wp = wp + 1;
    end
  end
  always @(posedge r_n) if (rs_n && !emp) rp = rp + 1;
  always @(negedge lsel) if (rs_n && !xi_n) rp = 0;
  assign q_en  = !r_n && rs_n && !emp;
  assign q_drv = mem[rp[9:0]];
  assign ef_n  = cfg ? cnt >= {3'h0, ae[6:0], 1'b0} : !emp;
  assign ff_n  = cfg ? 11'd1024 - cnt >= {3'h0, af[6:0], 1'b0} : !ful;
  assign xo_n  = cfg && af[8] ? !(emp || ful) : !(cnt > 11'd512);
endmodule

// File: tb_top.sv
// Testbench for the host controller with a behavioural FIFO device
// AXI4-Lite master tasks; expected results queued for a monitor
`timescale 1ns/10ps
module tb_top;
  reg CLK = 0, RST_N = 0, awvalid = 0, wvalid = 0, bready = 0;
  reg arvalid = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rd_v;
  wire awready, wready, bvalid, arready, rvalid, rs_n, w_n, r_n, ls, xi;
  wire oe, ef, ff, xo, qen;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [8:0] din, qo, qd, qb;
  reg [8:0] pat = 0, w [0:3];
  reg [65:0] rq [$];
  reg [1:0] bq [$];
  integer errors = 0, total_checks = 0, i, seed = 32'h994526db;
  always #25 CLK = ~CLK;
  // Floating bus shows a changing pattern
  always @(posedge CLK) pat <= ~pat;
  assign qb = oe ? qo : qen ? qd : pat;
  pff_host pff_host_inst (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RESET_N(rs_n), .WRITE_N(w_n), .READ_N(r_n),
    .LOAD_SELECT_PIN(ls), .CHAIN_INPUT_N(xi), .INPUT_BUS(din),
    .OUTPUT_BUS_I(qb), .OUTPUT_BUS_O(qo), .OUTPUT_BUS_OE(oe),
    .LOWER_STATUS_PIN(ef), .UPPER_STATUS_PIN(ff), .SHARED_THIRD_OUTPUT(xo));
  pff_fifo_model pff_fifo_model_inst (.rs_n(rs_n), .w_n(w_n), .r_n(r_n),
    .lsel(ls), .xi_n(xi), .d(din), .q_in(qb), .q_drv(qd), .q_en(qen),
    .ef_n(ef), .ff_n(ff), .xo_n(xo));
  ////////////////////////////////////////////////////////////////////////////
  task cmp_r(input [65:0] n, input [33:0] s);
    total_checks++;
    if (((s ^ n[33:0]) & {2'h3, n[65:34]}) !== 34'h0) begin
      errors++;
      $display("mismatch read exp %h got %h", n[33:0], s);
    end
  endtask
  task cmp_b(input [1:0] e, input [1:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch bresp exp %h got %h", e, s);
    end
  endtask
  always @(posedge CLK) begin
    if (rvalid && rready) cmp_r(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) cmp_b(bq.pop_front(), bresp);
  end
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    @(posedge CLK);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge CLK);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] m, input [33:0] e);
    @(posedge CLK);
    rq.push_back({m, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge CLK);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd_v = rdata;
    rready <= 0;
  endtask
  task cmd(input [31:0] c);
    wr(8'h00, c, 2'h0);
    rd_v = 1;
    while (rd_v[0] !== 1'b0) rd(8'h0c, 0, 0);
  endtask
  task final_report;
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1;
    cmd(3);
    rd(8'h0c, 15, 12);
    for (i = 0; i < 3; i++) begin
      w[i] = $random(seed);
      wr(8'h04, {23'h0, w[i]}, 2'h0);
      cmd(1);
    end
    rd(8'h0c, 15, 14);
    for (i = 0; i < 2; i++) begin
      cmd(2);
      rd(8'h08, 511, {25'h0, w[i]});
    end
    cmd(5);
    cmd(2);
    rd(8'h08, 511, {25'h0, w[0]});
    wr(8'h10, {14'h0, 9'h002, 9'h102}, 2'h0);
    cmd(32'h104);
    rd(8'h0c, 15, 4);
    for (i = 0; i < 5; i++) begin
      wr(8'h04, $random(seed), 2'h0);
      cmd(1);
      rd(8'h0c, 15, i >= 3 ? 14 : 12);
    end
    wr(8'h10, {14'h0, 9'h001, 9'h100}, 2'h0);
    cmd(4);
    rd(8'h0c, 15, 4);
    cmd(32'h205);
    rd(8'h00, 32'h707, 32'h205);
    rd(8'h40, 0, 34'h200000000);
    wr(8'h40, 0, 2'h2);
    final_report;
  end
endmodule
bind pff_host pff_host_chk #(.PULSE_CYC(PULSE_CYC)) pff_host_chk_inst (
  .CLK(CLK), .RST_N(RST_N), .RESET_N(RESET_N), .WRITE_N(WRITE_N),
  .READ_N(READ_N), .LOAD_SELECT_PIN(LOAD_SELECT_PIN),
  .CHAIN_INPUT_N(CHAIN_INPUT_N), .OUTPUT_BUS_OE(OUTPUT_BUS_OE));
